// >>> pkg/cesrc_pkg.sv
package cesrc_pkg;
    // Register byte addresses.
    localparam logic [7:0] REG_PORT_CFG = 8'h00;
    localparam logic [7:0] REG_CTX0 = 8'h04;
    localparam logic [7:0] REG_CTX1 = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_PHYS = 8'h10;
    // Field positions.
    localparam int CFG_ACT_BIT = 0;
    localparam int CTX0_MODE_LSB = 0;
    localparam int CTX0_SDT_BIT = 2;
    localparam int CTX0_AAL1_BIT = 3;
    localparam int CTX0_ROBUST_BIT = 4;
    localparam int CTX0_SEL_LSB = 5;
    localparam int CTX0_FILL_LSB = 8;
    localparam int CTX0_NSLOT_LSB = 16;
    localparam int CTX1_INI_LSB = 0;
    localparam int CTX1_LSIZE_LSB = 16;
    localparam int STS_STATE_LSB = 0;
    localparam int STS_OVF_BIT = 4;
    localparam int STS_UDF_BIT = 5;
    localparam int STS_RDY_BIT = 6;
    localparam int STS_CPB_LSB = 8;
    localparam int STS_LEVEL_LSB = 16;
    // Reset values.
    localparam logic [31:0] CTX0_RST = 32'h0001_2F00;
    localparam logic [31:0] CTX1_RST = 32'h0100_0000;
    // Channel modes and reassembly start-up sequence.
    typedef enum logic [1:0] {
        CESRC_M_INACT = 2'b00,
        CESRC_M_ACT = 2'b01,
        CESRC_M_STBY = 2'b10,
        CESRC_M_ACT2 = 2'b11
    } cesrc_mode_e;
    typedef enum logic [2:0] {
        SQ_UNDER = 3'b000,
        SQ_PREFILL = 3'b001,
        SQ_DROP = 3'b010,
        SQ_ALIGN = 3'b011,
        SQ_RUN = 3'b100
    } cesrc_seq_e;
    // Starvation byte patterns, selected by a two-bit field.
    localparam logic [7:0] STARV_PAT0 = 8'hFF;
    localparam logic [7:0] STARV_PAT1 = 8'h7F;
    localparam logic [7:0] STARV_PAT2 = 8'hD5;
    localparam logic [7:0] STARV_PAT3 = 8'h00;
    // Buffer geometry and cell filling band lower bounds.
    localparam int BLOCK_OCTETS = 64;
    localparam int BLOCKS_PER_SLOT = 8;
    localparam int BUF_DEPTH = 512;
    localparam logic [5:0] BAND_AAL0 [3] = '{6'd33, 6'd17, 6'd9};
    localparam logic [5:0] BAND_AAL1 [3] = '{6'd32, 6'd16, 6'd8};
    localparam logic [5:0] BAND_SDT [3] = '{6'd31, 6'd15, 6'd7};
    // Channel internal reset hold time.
    localparam int CLK_PERIOD_PS = 25000;
    localparam int T_CHRST_US = 250;
    localparam int CHRST_CYC = (T_CHRST_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
endpackage

// >>> hw/cesrc_slot_calc.sv
module cesrc_slot_calc
    import cesrc_pkg::*;
(
    input wire logic aal1,
    input wire logic sdt,
    input wire logic [5:0] fill,
    output logic [3:0] cells_per_block,
    output logic [6:0] slot_octets
);
    function automatic logic [5:0] band_low(input logic a1, input logic sd, input int idx);
        band_low = !a1 ? BAND_AAL0[idx] : (sd ? BAND_SDT[idx] : BAND_AAL1[idx]);
    endfunction

    logic [1:0] shift;

    always_comb begin
        if (fill >= band_low(aal1, sdt, 0)) begin
            shift = 2'd0;
        end else if (fill >= band_low(aal1, sdt, 1)) begin
            shift = 2'd1;
        end else if (fill >= band_low(aal1, sdt, 2)) begin
            shift = 2'd2;
        end else begin
            shift = 2'd3;
        end
        cells_per_block = 4'(4'd1 << shift);
        slot_octets = 7'(BLOCK_OCTETS >> shift);
    end
endmodule

// >>> hw/cesrc_channel.sv
// Contract
// - Inactive: reject cells, send pattern zero.
// - Standby: accept cells, still send pattern zero.
// - Active: accept cells, forward reassembled octets.
// - Split 64-octet block by cell filling.
// - Physical size is N*8*fill*cells per block.
// - Unstructured: no cell means starvation output.
// - First cell: starv_ini plus one starvation.
// - Fill count, pattern, size from context.
// - Structured: starve until first pointer cell.
// - Drop pointer octets, one starvation each.
// - Starve until framer structure start request.
// - Starts coincide: forward buffered octets in order.
// - Logical size programmable to catch overflow.
// - Robust count holds cell; one cell margin.
// - Fast count writes accepted cell immediately.
// - Flag overflow when cell exceeds logical size.
//
// The implementer's own choices: the placing of the registers and strobed register access.
module cesrc_channel
    import cesrc_pkg::*;
#(
    parameter int RST_HOLD_CYC = CHRST_CYC,
    parameter int DEPTH = BUF_DEPTH
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic cell_valid,
    input wire logic cell_sop,
    input wire logic cell_eop,
    input wire logic [7:0] cell_data,
    input wire logic cell_pfmt,
    input wire logic [6:0] cell_ptr,
    output logic cell_taken,
    input wire logic fr_req,
    input wire logic fr_sos,
    output logic fr_valid,
    output logic fr_user,
    output logic [7:0] fr_data
);
    localparam int PW = $clog2(DEPTH) + 1;
    localparam int RW = $clog2(RST_HOLD_CYC + 1);

    function automatic logic [7:0] starv_pat(input logic [1:0] sel);
        unique case (sel)
            2'd0: starv_pat = STARV_PAT0;
            2'd1: starv_pat = STARV_PAT1;
            2'd2: starv_pat = STARV_PAT2;
            2'd3: starv_pat = STARV_PAT3;
        endcase
    endfunction

    // Register group.
    logic act_r, act_nxt;
    logic [31:0] ctx0_r, ctx0_nxt, ctx1_r, ctx1_nxt, rdata_r, rdata_nxt;
    logic ovf_r, ovf_nxt, udf_r, udf_nxt;
    logic [RW-1:0] rcnt_r, rcnt_nxt;
    // Buffer group.
    logic [7:0] mem [DEPTH];
    logic [PW-1:0] wr_r, wr_nxt, com_r, com_nxt, rd_r, rd_nxt;
    logic take_r, take_nxt, ptr_seen_r, ptr_seen_nxt;
    logic [6:0] ptr_r, ptr_nxt;
    // Output group.
    cesrc_seq_e seq_r, seq_nxt;
    logic [9:0] cnt_r, cnt_nxt;
    logic fv_r, fv_nxt, fu_r, fu_nxt;
    logic [7:0] fd_r, fd_nxt;

    cesrc_mode_e mode;
    logic sdt, aal1, robust, rdy, chan_on, user_mode, take_now, ovf_ev, udf_ev, wr_en, rd_en, full;
    logic [1:0] sel;
    logic [5:0] fill, nslot;
    logic [9:0] ini, lsize;
    logic [PW-1:0] level, held;
    logic [10:0] need;
    logic [3:0] cpb;
    logic [17:0] phys;

    assign mode = cesrc_mode_e'(ctx0_r[CTX0_MODE_LSB +: 2]);
    assign sdt = ctx0_r[CTX0_SDT_BIT];
    assign aal1 = ctx0_r[CTX0_AAL1_BIT];
    assign robust = ctx0_r[CTX0_ROBUST_BIT];
    assign sel = ctx0_r[CTX0_SEL_LSB +: 2];
    assign fill = ctx0_r[CTX0_FILL_LSB +: 6];
    assign nslot = ctx0_r[CTX0_NSLOT_LSB +: 6];
    assign ini = ctx1_r[CTX1_INI_LSB +: 10];
    assign lsize = ctx1_r[CTX1_LSIZE_LSB +: 10];

    cesrc_slot_calc u_slot (
        .aal1(aal1),
        .sdt(sdt),
        .fill(fill),
        .cells_per_block(cpb),
        .slot_octets()
    );

    assign phys = 18'(nslot) * 18'(BLOCKS_PER_SLOT) * 18'(fill) * 18'(cpb);

    // The channel stays in reset until activation was held with mode 00 long enough.
    assign rdy = (rcnt_r == RW'(RST_HOLD_CYC));
    assign chan_on = act_r && rdy && (mode != CESRC_M_INACT);
    assign user_mode = chan_on && ctx0_r[CTX0_MODE_LSB];
    assign level = com_r - rd_r;
    assign held = wr_r - com_r;
    assign full = ((wr_r - rd_r) == PW'(DEPTH));
    // Committed octets plus a held robust cell plus the new cell against the logical size.
    assign need = 11'(level) + 11'(held) + 11'(fill);
    assign ovf_ev = cell_valid && cell_sop && chan_on && (need > 11'(lsize));
    // Structured start-up discards cells until the first pointer-format cell.
    assign take_now = chan_on && !ovf_ev && (!sdt || ptr_seen_r || cell_pfmt);
    assign cell_taken = cell_sop ? take_now : take_r;
    assign wr_en = cell_valid && cell_taken && !full;

    always_comb begin
        act_nxt = act_r;
        ctx0_nxt = ctx0_r;
        ctx1_nxt = ctx1_r;
        ovf_nxt = ovf_r;
        udf_nxt = udf_r;
        rdata_nxt = 32'h0000_0000;
        rcnt_nxt = rcnt_r;
        if (reg_wr) begin
            unique case (reg_addr)
                REG_PORT_CFG: act_nxt = reg_wdata[CFG_ACT_BIT];
                REG_CTX0: ctx0_nxt = reg_wdata;
                REG_CTX1: ctx1_nxt = reg_wdata;
                REG_STATUS: begin
                    if (reg_wdata[STS_OVF_BIT]) begin
                        ovf_nxt = 1'b0;
                    end
                    if (reg_wdata[STS_UDF_BIT]) begin
                        udf_nxt = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // Hardware events win over a clear in the same cycle.
        if (ovf_ev) begin
            ovf_nxt = 1'b1;
        end
        if (udf_ev) begin
            udf_nxt = 1'b1;
        end
        if (!act_r) begin
            rcnt_nxt = '0;
        end else if (mode == CESRC_M_INACT && !rdy) begin
            rcnt_nxt = rcnt_r + RW'(1);
        end
        if (reg_rd) begin
            unique case (reg_addr)
                REG_PORT_CFG: rdata_nxt[CFG_ACT_BIT] = act_r;
                REG_CTX0: rdata_nxt = ctx0_r;
                REG_CTX1: rdata_nxt = ctx1_r;
                REG_STATUS: begin
                    rdata_nxt[STS_STATE_LSB +: 3] = seq_r;
                    rdata_nxt[STS_OVF_BIT] = ovf_r;
                    rdata_nxt[STS_UDF_BIT] = udf_r;
                    rdata_nxt[STS_RDY_BIT] = rdy;
                    rdata_nxt[STS_CPB_LSB +: 4] = cpb;
                    rdata_nxt[STS_LEVEL_LSB +: PW] = level;
                end
                REG_PHYS: rdata_nxt[17:0] = phys;
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            act_r <= 1'b0;
            ctx0_r <= CTX0_RST;
            ctx1_r <= CTX1_RST;
            ovf_r <= 1'b0;
            udf_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rcnt_r <= '0;
        end else begin
            act_r <= act_nxt;
            ctx0_r <= ctx0_nxt;
            ctx1_r <= ctx1_nxt;
            ovf_r <= ovf_nxt;
            udf_r <= udf_nxt;
            rdata_r <= rdata_nxt;
            rcnt_r <= rcnt_nxt;
        end
    end
    assign reg_rdata = rdata_r;

    always_comb begin
        wr_nxt = wr_en ? wr_r + PW'(1) : wr_r;
        com_nxt = com_r;
        rd_nxt = rd_en ? rd_r + PW'(1) : rd_r;
        take_nxt = take_r;
        ptr_seen_nxt = ptr_seen_r;
        ptr_nxt = ptr_r;
        if (cell_valid && cell_sop) begin
            take_nxt = take_now;
            // A robust cell is only committed once the next cell shows up.
            if (chan_on && robust) begin
                com_nxt = wr_r;
            end
            if (take_now && cell_pfmt && !ptr_seen_r) begin
                ptr_seen_nxt = 1'b1;
                ptr_nxt = cell_ptr;
            end
        end
        if (wr_en && cell_eop && !robust) begin
            com_nxt = wr_nxt;
        end
        if (cell_valid && cell_eop) begin
            take_nxt = 1'b0;
        end
        if (!chan_on) begin
            wr_nxt = '0;
            com_nxt = '0;
            rd_nxt = '0;
            take_nxt = 1'b0;
            ptr_seen_nxt = 1'b0;
            ptr_nxt = '0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_r[PW-2:0]] <= cell_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wr_r <= '0;
            com_r <= '0;
            rd_r <= '0;
            take_r <= 1'b0;
            ptr_seen_r <= 1'b0;
            ptr_r <= '0;
        end else begin
            wr_r <= wr_nxt;
            com_r <= com_nxt;
            rd_r <= rd_nxt;
            take_r <= take_nxt;
            ptr_seen_r <= ptr_seen_nxt;
            ptr_r <= ptr_nxt;
        end
    end

    always_comb begin
        seq_nxt = seq_r;
        cnt_nxt = cnt_r;
        fv_nxt = fr_req;
        fu_nxt = 1'b0;
        fd_nxt = user_mode ? starv_pat(sel) : STARV_PAT0;
        rd_en = 1'b0;
        udf_ev = 1'b0;
        if (user_mode) begin
            unique case (seq_r)
                SQ_UNDER: begin
                    if (level != '0 && (!sdt || ptr_seen_r)) begin
                        seq_nxt = SQ_PREFILL;
                        cnt_nxt = ini;
                    end
                end
                SQ_PREFILL: begin
                    if (fr_req) begin
                        cnt_nxt = cnt_r - 10'd1;
                        if (cnt_r == '0) begin
                            seq_nxt = !sdt ? SQ_RUN : (ptr_r != '0 ? SQ_DROP : SQ_ALIGN);
                            cnt_nxt = 10'(ptr_r) - 10'd1;
                        end
                    end
                end
                SQ_DROP: begin
                    if (fr_req && level != '0) begin
                        rd_en = 1'b1;
                        cnt_nxt = cnt_r - 10'd1;
                        if (cnt_r == '0) begin
                            seq_nxt = SQ_ALIGN;
                        end
                    end
                end
                SQ_ALIGN, SQ_RUN: begin
                    if (fr_req && (seq_r == SQ_RUN || fr_sos)) begin
                        seq_nxt = SQ_RUN;
                        if (level != '0) begin
                            rd_en = 1'b1;
                            fu_nxt = 1'b1;
                            fd_nxt = mem[rd_r[PW-2:0]];
                        end else begin
                            udf_ev = 1'b1;
                        end
                    end
                end
                default: seq_nxt = SQ_UNDER;
            endcase
        end else begin
            seq_nxt = SQ_UNDER;
            cnt_nxt = '0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            seq_r <= SQ_UNDER;
            cnt_r <= '0;
            fv_r <= 1'b0;
            fu_r <= 1'b0;
            fd_r <= STARV_PAT0;
        end else begin
            seq_r <= seq_nxt;
            cnt_r <= cnt_nxt;
            fv_r <= fv_nxt;
            fu_r <= fu_nxt;
            fd_r <= fd_nxt;
        end
    end
    assign fr_valid = fv_r;
    assign fr_user = fu_r;
    assign fr_data = fd_r;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence s_enter_prefill;
        seq_r == SQ_UNDER ##1 seq_r == SQ_PREFILL;
    endsequence
    sequence s_prefill_last;
        seq_r == SQ_PREFILL && cnt_r == '0 && fr_req && user_mode;
    endsequence

    property p_inact_pattern;
        (mode == CESRC_M_INACT && fr_req) |=> (fr_valid && !fr_user && fr_data == STARV_PAT0);
    endproperty
    a_inact_pattern: assert property (p_inact_pattern) else $error("inactive output not pattern zero");
    property p_inact_reject;
        (mode == CESRC_M_INACT && cell_valid) |-> !wr_en ##1 wr_r == '0;
    endproperty
    a_inact_reject: assert property (p_inact_reject) else $error("inactive channel stored a cell");
    property p_stby_pattern;
        (mode == CESRC_M_STBY && fr_req) |=> (!fr_user && fr_data == STARV_PAT0);
    endproperty
    a_stby_pattern: assert property (p_stby_pattern) else $error("standby sent user data");
    property p_one_octet;
        fr_req |=> fr_valid ##1 (fr_valid == $past(fr_req));
    endproperty
    a_one_octet: assert property (p_one_octet) else $error("request not answered by one octet");
    property p_under_starve;
        (seq_r == SQ_UNDER && fr_req) |=> !fr_user;
    endproperty
    a_under_starve: assert property (p_under_starve) else $error("user data during underflow");
    property p_prefill_count;
        s_enter_prefill |-> cnt_r == ini;
    endproperty
    a_prefill_count: assert property (p_prefill_count) else $error("prefill count not initial fill");
    property p_prefill_end;
        s_prefill_last |=> seq_r != SQ_PREFILL && !fr_user;
    endproperty
    a_prefill_end: assert property (p_prefill_end) else $error("prefill did not end");
    property p_drop;
        (seq_r == SQ_DROP && fr_req && level != '0 && user_mode) |=> (rd_r == $past(rd_r) + PW'(1)) && !fr_user;
    endproperty
    a_drop: assert property (p_drop) else $error("pointer octet not dropped");
    property p_align_wait;
        (seq_r == SQ_ALIGN && fr_req && !fr_sos && user_mode) |=> !fr_user && seq_r == SQ_ALIGN;
    endproperty
    a_align_wait: assert property (p_align_wait) else $error("left alignment without structure start");
    property p_ovf_flag;
        ovf_ev |=> ovf_r ##1 ovf_r;
    endproperty
    a_ovf_flag: assert property (p_ovf_flag) else $error("overflow not flagged");
    property p_fast_commit;
        (wr_en && cell_eop && !robust && chan_on) |=> com_r == wr_r;
    endproperty
    a_fast_commit: assert property (p_fast_commit) else $error("fast cell not committed");
endmodule

// >>> testbench/cesrc_far.sv
// Far side: a cell source and a framer that asks for one octet per timeslot.
module cesrc_far (
    input wire logic core_clk,
    input wire logic cell_taken,
    input wire logic fr_valid,
    input wire logic fr_user,
    input wire logic [7:0] fr_data,
    output logic cell_valid,
    output logic cell_sop,
    output logic cell_eop,
    output logic [7:0] cell_data,
    output logic cell_pfmt,
    output logic [6:0] cell_ptr,
    output logic fr_req,
    output logic fr_sos
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cell_valid = 1'b0;
        cell_sop = 1'b0;
        cell_eop = 1'b0;
        cell_data = 8'h00;
        cell_pfmt = 1'b0;
        cell_ptr = 7'h00;
        fr_req = 1'b0;
        fr_sos = 1'b0;
    end
    // The data line toggles when idle so a stale octet is never mistaken for a fresh one.
    task automatic send_cell(input int n, input logic [7:0] base, input logic pf, input logic [6:0] ptr,
                             input bit slow, output logic taken);
        for (int i = 0; i < n; i++) begin
            if (slow && i > 0) begin
                @(posedge core_clk);
                cell_valid <= 1'b0;
                cell_data <= ~cell_data;
            end
            @(posedge core_clk);
            cell_valid <= 1'b1;
            cell_sop <= (i == 0);
            cell_eop <= (i == n - 1);
            cell_data <= base + 8'(i);
            cell_pfmt <= pf;
            cell_ptr <= ptr;
            if (i == 0) begin
                #1;
                taken = cell_taken;
            end
        end
        @(posedge core_clk);
        cell_valid <= 1'b0;
        cell_sop <= 1'b0;
        cell_eop <= 1'b0;
        cell_data <= ~cell_data;
    endtask
    // One timeslot request; the answer stands only in the cycle after it.
    task automatic fr_octet(input logic sos, output logic v, output logic u, output logic [7:0] d);
        @(posedge core_clk);
        fr_req <= 1'b1;
        fr_sos <= sos;
        @(posedge core_clk);
        fr_req <= 1'b0;
        fr_sos <= 1'b0;
        #1;
        v = fr_valid;
        u = fr_user;
        d = fr_data;
    endtask
endmodule

// >>> testbench/cesrc_channel_tb.sv
module cesrc_channel_tb
    import cesrc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HOLD = 20;
    logic core_clk = 1'b0;
    logic sys_rst, reg_wr, reg_rd, cell_valid, cell_sop, cell_eop, cell_pfmt, cell_taken;
    logic fr_req, fr_sos, fr_valid, fr_user, v, u, tk;
    logic [7:0] reg_addr, cell_data, fr_data, d, base;
    logic [31:0] reg_wdata, reg_rdata, r;
    logic [6:0] cell_ptr, p;
    logic [5:0] f;
    logic [9:0] ini;
    logic [1:0] sel;
    int miscompares = 0;
    int cmp_count = 0;
    int cycles = 0;
    int fills [13] = '{4, 6, 7, 8, 9, 15, 16, 17, 30, 31, 32, 33, 47};

    cesrc_channel #(.RST_HOLD_CYC(HOLD), .DEPTH(BUF_DEPTH)) cesrc_channel_i (
        .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cell_valid(cell_valid),
        .cell_sop(cell_sop), .cell_eop(cell_eop), .cell_data(cell_data), .cell_pfmt(cell_pfmt),
        .cell_ptr(cell_ptr), .cell_taken(cell_taken), .fr_req(fr_req), .fr_sos(fr_sos),
        .fr_valid(fr_valid), .fr_user(fr_user), .fr_data(fr_data));
    cesrc_far cesrc_far_i (
        .core_clk(core_clk), .cell_taken(cell_taken), .fr_valid(fr_valid), .fr_user(fr_user),
        .fr_data(fr_data), .cell_valid(cell_valid), .cell_sop(cell_sop), .cell_eop(cell_eop),
        .cell_data(cell_data), .cell_pfmt(cell_pfmt), .cell_ptr(cell_ptr), .fr_req(fr_req),
        .fr_sos(fr_sos));

    initial begin
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons=%0d mismatches=%0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            miscompares++;
            print_verdict();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] w);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= w;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        q = reg_rdata;
    endtask

    function automatic logic [3:0] cpb(input logic a1, input logic sdt, input int n);
        int b;
        b = 33 - int'(a1) - int'(sdt);
        return (n >= b) ? 4'h1 : (n >= b - 16) ? 4'h2 : (n >= b - 24) ? 4'h4 : 4'h8;
    endfunction

    function automatic logic [31:0] ctx0(input logic [1:0] m, input logic sdt, input logic a1, input logic [1:0] s,
                                         input logic [5:0] n);
        return {10'h000, 6'h01, 2'h0, n, 1'h0, s, 1'h0, a1, sdt, m};
    endfunction

    function automatic logic [7:0] pat(input logic [1:0] s);
        return s == 2'h0 ? STARV_PAT0 : s == 2'h1 ? STARV_PAT1 : s == 2'h2 ? STARV_PAT2 : STARV_PAT3;
    endfunction

    task automatic starve(input int n, input logic [7:0] exp);
        for (int i = 0; i < n; i++) begin
            cesrc_far_i.fr_octet(1'b0, v, u, d);
            check({v, u, d}, {2'b10, exp});
        end
    endtask

    // The framer keeps running through the channel reset so frame timing can be picked up.
    task automatic bring_up(input logic [31:0] c0, input logic [9:0] i0, input logic [9:0] lsz);
        wr(REG_PORT_CFG, 32'h0000_0000);
        wr(REG_CTX0, {c0[31:2], 2'b00});
        wr(REG_CTX1, {6'h00, lsz, 6'h00, i0});
        wr(REG_STATUS, 32'h0000_0030);
        wr(REG_PORT_CFG, 32'h0000_0001);
        rd(REG_STATUS, r);
        check(r[STS_RDY_BIT], 1'b0);
        starve(HOLD / 2 + 2, STARV_PAT0);
        rd(REG_STATUS, r);
        check(r[STS_RDY_BIT], 1'b1);
        wr(REG_CTX0, c0);
    endtask

    initial begin
        sys_rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        r = $urandom(41);
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;

        rd(REG_CTX0, r);
        check(r, CTX0_RST);
        rd(REG_CTX1, r);
        check(r, CTX1_RST);
        rd(8'h20, r);
        check(r, 32'h0000_0000);
        cesrc_far_i.send_cell(8, 8'h10, 1'b0, 7'h00, 1'b0, tk);
        check(tk, 1'b0);
        starve(1, STARV_PAT0);
        $display("test reset and inactive done");

        for (int m = 0; m < 3; m++) begin
            for (int k = 0; k < 14; k++) begin
                f = (k < 13) ? 6'(fills[k]) : 6'($urandom_range(47, 4));
                wr(REG_CTX0, ctx0(2'b00, m == 2, m > 0, 2'h0, f));
                rd(REG_STATUS, r);
                check(r[11:8], cpb(m > 0, m == 2, f));
                rd(REG_PHYS, r);
                check(r[17:0], 18'(8 * int'(f) * int'(cpb(m > 0, m == 2, f))));
            end
        end
        $display("test geometry done");

        bring_up(ctx0(2'b10, 1'b0, 1'b0, 2'h1, 6'h0C), 10'h002, 10'h3FF);
        cesrc_far_i.send_cell(12, 8'h40, 1'b0, 7'h00, 1'b0, tk);
        check(tk, 1'b1);
        starve(3, STARV_PAT0);
        $display("test standby done");

        // Both codes of the active mode; the second cell arrives with idle gaps between octets.
        for (int m = 0; m < 2; m++) begin
            sel = 2'($urandom_range(3));
            ini = 10'($urandom_range(6));
            f = 6'($urandom_range(20, 8));
            base = 8'($urandom);
            bring_up(ctx0(m ? 2'b11 : 2'b01, 1'b0, 1'b0, sel, f), ini, 10'h100);
            starve(2, pat(sel));
            cesrc_far_i.send_cell(int'(f), base, 1'b0, 7'h00, m == 1, tk);
            check(tk, 1'b1);
            rd(REG_STATUS, r);
            check(r[25:16], 10'(f));
            starve(int'(ini) + 1, pat(sel));
            for (int i = 0; i < int'(f); i++) begin
                cesrc_far_i.fr_octet(1'b0, v, u, d);
                check({v, u, d}, {2'b11, base + 8'(i)});
            end
            starve(1, pat(sel));
            rd(REG_STATUS, r);
            check(r[STS_UDF_BIT], 1'b1);
        end
        $display("test unstructured done");

        // A logical size of one cell makes the second cell overflow.
        bring_up(ctx0(2'b01, 1'b0, 1'b0, 2'h0, 6'h0A), 10'h001, 10'h00A);
        cesrc_far_i.send_cell(10, 8'h80, 1'b0, 7'h00, 1'b0, tk);
        check(tk, 1'b1);
        cesrc_far_i.send_cell(10, 8'h90, 1'b0, 7'h00, 1'b0, tk);
        check(tk, 1'b0);
        rd(REG_STATUS, r);
        check({r[STS_OVF_BIT], r[25:16]}, {1'b1, 10'h00A});
        $display("test overflow done");

        // Robust counting holds each cell back until the next one starts.
        bring_up(ctx0(2'b01, 1'b0, 1'b0, 2'h0, 6'h08) | 32'h0000_0010, 10'h000, 10'h100);
        cesrc_far_i.send_cell(8, 8'h20, 1'b0, 7'h00, 1'b0, tk);
        rd(REG_STATUS, r);
        check(r[25:16], 10'h000);
        cesrc_far_i.send_cell(8, 8'h28, 1'b0, 7'h00, 1'b0, tk);
        rd(REG_STATUS, r);
        check(r[25:16], 10'h008);
        $display("test robust done");

        // Frame based structure: one frame per structure, N of one, so the span is one octet.
        sel = 2'($urandom_range(3));
        ini = 10'($urandom_range(4));
        p = 7'($urandom_range(5, 1));
        f = 6'h14;
        base = 8'($urandom);
        bring_up(ctx0(2'b01, 1'b1, 1'b1, sel, f), ini, 10'(int'(f) + int'(ini) + 1 + 1 + 1 + 8));
        cesrc_far_i.send_cell(int'(f), base, 1'b0, 7'h00, 1'b0, tk);
        check(tk, 1'b0);
        starve(1, pat(sel));
        cesrc_far_i.send_cell(int'(f), base, 1'b1, p, 1'b0, tk);
        check(tk, 1'b1);
        rd(REG_STATUS, r);
        check(r[25:16], 10'(f));
        starve(int'(ini) + 1 + int'(p), pat(sel));
        starve(2, pat(sel));
        cesrc_far_i.fr_octet(1'b1, v, u, d);
        check({v, u, d}, {2'b11, base + 8'(p)});
        cesrc_far_i.fr_octet(1'b0, v, u, d);
        check({v, u, d}, {2'b11, base + 8'(p) + 8'h01});
        $display("test structured done");
        print_verdict();
    end
endmodule
